// ---- design/bmseq_core.v ----
// block move sequencer: copies bytes from source to destination pointer
// assumes a simple memory port with a one-cycle ready handshake
`timescale 1ns/1ps
`include "bmseq_defines.vh"
module bmseq_core #(
    parameter AW = `BMSEQ_ADDR_W,
    parameter CW = `BMSEQ_CNT_W
) (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire word_mode,
    input wire [CW-1:0] count_in,
    input wire [AW-1:0] src_in,
    input wire [AW-1:0] dst_in,
    input wire mem_ready,
    input wire [7:0] mem_rdata,
    output reg busy_q,
    output reg done_q,
    output reg mem_req_q,
    output reg mem_we_q,
    output reg [AW-1:0] mem_addr_q,
    output reg [7:0] mem_wdata_q,
    output reg [CW-1:0] count_q,
    output reg [AW-1:0] src_q,
    output reg [AW-1:0] dst_q
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_SETUP = 6'h02;
    localparam [5:0] S_READ = 6'h04;
    localparam [5:0] S_WRITE = 6'h08;
    localparam [5:0] S_PAD = 6'h10;
    localparam [5:0] S_TAIL = 6'h20;

    // timing walk with memory answering at once, c0 being the start edge:
    //   c0      start taken, registers loaded, timer armed for setup
    //   c1..c3  setup countdown, no memory traffic yet
    //   c4      first read issued at the source pointer
    //   c5      read answered, write issued at the destination pointer
    //   c6      write answered, pointers and count stepped, pad armed
    //   c7      pad state, waits for the timer
    //   c8      next read issued, so each byte costs four states
    // after the last byte the pad is stretched by the tail count, so the
    // done pulse lands close to the fixed overhead plus four per byte.
    // a zero count leaves setup straight for the pad and the tail, which
    // is a couple of states shorter than the full overhead; no memory
    // request is ever raised on that path.
    //
    // hazard: a slow memory holds ready low for any number of states; the
    // read and write states simply wait, so the total length is variable
    // and nothing downstream may assume the fixed figure in that case.
    //
    // limitation: only one access is outstanding at a time, so there is
    // no overlap of the write of one byte with the read of the next; the
    // four-state pace leaves room for that without buffering.

    // timer reloads, cut to the timer width on purpose
    localparam integer SETUP_I = `BMSEQ_SETUP_STATES - 1;
    localparam integer TAIL_I = `BMSEQ_TAIL_STATES - 1;
    // read and write take one state each when ready at once; pad fills to 4
    localparam integer PAD_I = `BMSEQ_BYTE_STATES - 3;
    localparam [3:0] SETUP_N = SETUP_I[3:0];
    localparam [3:0] TAIL_N = TAIL_I[3:0];
    localparam [3:0] PAD_N = PAD_I[3:0];

    reg [5:0] state_q;
    reg t_load;
    reg [3:0] t_val;
    wire t_done;

    // one shared timer paces setup, pad and tail; it steps every clock
    bmseq_step_timer #(.W(`BMSEQ_TMR_W)) u_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .load(t_load),
        .load_val(t_val),
        .step(1'b1),
        .done_q(t_done)
    );

    // effective count: byte variant sees only the low byte
    wire [CW-1:0] eff_cnt = word_mode ? count_in : {{(CW-8){1'b0}}, count_in[7:0]};
    wire last_byte = (count_q == {{(CW-1){1'b0}}, 1'b1});

    // timer loads on entry to setup and on entry to pad from a write
    always @* begin
        t_load = 1'b0;
        t_val = 4'h0;
        if (state_q == S_IDLE && start) begin
            t_load = 1'b1;
            t_val = SETUP_N;
        end else if (state_q == S_WRITE && mem_ready && mem_req_q) begin
            t_load = 1'b1;
            t_val = last_byte ? TAIL_N + PAD_N : PAD_N;
        end
    end

    // main sequencer; condition flags are not part of this block at all
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= {AW{1'b0}};
            mem_wdata_q <= 8'h00;
            count_q <= {CW{1'b0}};
            src_q <= {AW{1'b0}};
            dst_q <= {AW{1'b0}};
        end else begin
            done_q <= 1'b0;
            case (state_q)
                // waits for a start; a start while busy never reaches here
                S_IDLE: begin
                    if (start) begin
                        busy_q <= 1'b1;
                        count_q <= eff_cnt;
                        src_q <= src_in;
                        dst_q <= dst_in;
                        state_q <= S_SETUP;
                    end
                end
                // fixed setup overhead before any memory traffic
                S_SETUP: begin
                    if (t_done) begin
                        if (count_q == {CW{1'b0}}) begin
                            // skip straight to the pad, then the tail, with nothing moved
                            state_q <= S_PAD;
                        end else begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b0;
                            mem_addr_q <= src_q;
                            state_q <= S_READ;
                        end
                    end
                end
                // read of the source byte, held until memory answers
                S_READ: begin
                    // slow-clock memory holds ready low; just wait
                    if (mem_ready) begin
                        mem_we_q <= 1'b1;
                        mem_addr_q <= dst_q;
                        mem_wdata_q <= mem_rdata;
                        state_q <= S_WRITE;
                    end
                end
                // write of the byte just read, then step the registers
                S_WRITE: begin
                    if (mem_ready) begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        src_q <= src_q + {{(AW-1){1'b0}}, 1'b1};
                        dst_q <= dst_q + {{(AW-1){1'b0}}, 1'b1};
                        count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
                        state_q <= S_PAD;
                    end
                end
                // fills each byte to its four states; also carries the tail
                S_PAD: begin
                    if (t_done) begin
                        if (count_q != {CW{1'b0}}) begin
                            mem_req_q <= 1'b1;
                            mem_addr_q <= src_q;
                            state_q <= S_READ;
                        end else begin
                            state_q <= S_TAIL;
                        end
                    end
                end
                // one-cycle done pulse; a new start may follow at once
                S_TAIL: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                // illegal code: recover to idle rather than hang
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // bmseq_core

// ---- design/bmseq_defines.vh ----
// constants for the block move sequencer: register widths and state timing
// assumes inclusion by bare name from the design files
`ifndef BMSEQ_DEFINES_VH
`define BMSEQ_DEFINES_VH
`define BMSEQ_ADDR_W 16
`define BMSEQ_DATA_W 8
`define BMSEQ_CNT_W 16
// fixed overhead states and states per byte, on-chip code
`define BMSEQ_BASE_STATES 8
`define BMSEQ_BYTE_STATES 4
// overhead split: setup before copying, tail after
`define BMSEQ_SETUP_STATES 4
`define BMSEQ_TAIL_STATES 4
`define BMSEQ_TMR_W 4
`endif

// ---- design/bmseq_step_timer.v ----
// state counter used to pace the sequencer phases
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module bmseq_step_timer #(
    parameter W = 4
) (
    input wire clk,
    input wire arst_n,
    input wire load,
    input wire [W-1:0] load_val,
    input wire step,
    output reg done_q
);
    reg [W-1:0] cnt_q;
    // counts down on each step; done while zero
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {W{1'b0}};
            done_q <= 1'b1;
        end else if (load) begin
            cnt_q <= load_val;
            done_q <= (load_val == {W{1'b0}});
        end else if (step && cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule // bmseq_step_timer

// ---- test/bmseq_checker.sv ----
// checker: sequencing properties of the block move core
// assumes binding to the bmseq_core ports
`timescale 1ns/1ps
module bmseq_checker #(parameter AW = 16, parameter CW = 16) (
    input wire clk, arst_n, start, word_mode, mem_ready, busy_q, done_q, mem_req_q, mem_we_q,
    input wire [CW-1:0] count_in, count_q,
    input wire [AW-1:0] mem_addr_q, src_q, dst_q,
    input wire [7:0] mem_rdata, mem_wdata_q);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // byte mode only looks at the low count byte
    wire zs = start && !busy_q && (word_mode ? count_in == 0 : count_in[7:0] == 0);
    wire rd = mem_req_q && !mem_we_q && mem_ready;
    wire wr = mem_req_q && mem_we_q && mem_ready;
    a_zero_skip: assert property (zs |=> !mem_req_q [*8]) else $error("zero access");
    a_zero_done: assert property (zs |-> ##[1:12] done_q) else $error("zero slow");
    a_read_src: assert property (rd |-> mem_addr_q == src_q) else $error("read addr");
    a_write_copy: assert property (rd |=> mem_we_q && mem_wdata_q == $past(mem_rdata)
        && mem_addr_q == dst_q) else $error("bad write");
    a_ptr_step: assert property (wr |=> src_q == $past(src_q) + 1'b1
        && count_q == $past(count_q) - 1'b1) else $error("bad step");
    a_req_hold: assert property (mem_req_q && !mem_ready |=> mem_req_q
        && $stable(mem_addr_q)) else $error("req dropped");
    a_done_zero: assert property (done_q |-> count_q == 0) else $error("count left");
    cover property (zs);
    cover property (wr && count_q == 1);
    cover property (mem_req_q && !mem_ready);
endmodule // bmseq_checker
bind bmseq_core bmseq_checker #(.AW(AW), .CW(CW)) bmseq_checker_inst (.*);

// ---- test/tb.sv ----
// bench: table of moves plus hand tests, memory reads give addr xor 5A
// assumes the design and checker are compiled first
`timescale 1ns/1ps
module tb;
    reg clk = 0, arst_n = 0, start = 0, word_mode = 0, mem_ready = 1, slow = 0;
    reg [15:0] count_in = 0, src_in = 0, dst_in = 0, es, ed, wn;
    wire busy_q, done_q, mem_req_q, mem_we_q;
    wire [15:0] mem_addr_q, count_q, src_q, dst_q;
    wire [7:0] mem_wdata_q;
    wire [7:0] mem_rdata = mem_addr_q[7:0] ^ 8'h5A;
    integer mismatches = 0, cmp_count = 0, cyc, i;
    reg [48:0] rows [0:3];
    bmseq_core bmseq_core_inst (.clk(clk), .arst_n(arst_n), .start(start),
        .word_mode(word_mode), .count_in(count_in), .src_in(src_in), .dst_in(dst_in),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy_q(busy_q), .done_q(done_q),
        .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .count_q(count_q), .src_q(src_q), .dst_q(dst_q));
    initial forever #2 clk = ~clk;
    task chk(input [15:0] g, e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // slow memory answers every other cycle
    always @(posedge clk) mem_ready <= slow ? ~mem_ready : 1'b1;
    // each write lands on the next destination with the source byte
    always @(posedge clk) if (mem_req_q && mem_we_q && mem_ready) begin
        chk(mem_addr_q, ed);
        chk(mem_wdata_q, es[7:0] ^ 8'h5A);
        es = es + 1;
        ed = ed + 1;
        wn = wn + 1;
    end
    task final_report;
        begin
            $display("mismatches %0d compares %0d", mismatches, cmp_count);
            if (mismatches == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // t=1 checks timing; t=0 pokes a refused start while busy
    task run(input wm, input [15:0] c, s, d, input t);
        reg [15:0] n;
        begin
            n = wm ? c : {8'h00, c[7:0]};
            es = s;
            ed = d;
            wn = 0;
            cyc = 0;
            @(posedge clk);
            start <= 1;
            word_mode <= wm;
            count_in <= c;
            src_in <= s;
            dst_in <= d;
            @(posedge clk);
            start <= !t;
            count_in <= 16'h0009;
            @(negedge clk);
            while (!done_q && cyc < 5000) begin
                @(posedge clk);
                start <= 0;
                @(negedge clk);
                cyc = cyc + 1;
            end
            chk(wn, n);
            chk(busy_q, 0);
            chk(count_q, 0);
            chk(src_q, s + n);
            chk(dst_q, d + n);
            if (t) chk(cyc + 5 >= 4 * n + 8 && cyc <= 4 * n + 12, 1);
        end
    endtask
    initial begin
        rows[0] = {1'b0, 16'h0003, 16'h1000, 16'h2000};
        rows[1] = {1'b1, 16'h0005, 16'hFFFE, 16'h3000};
        rows[2] = {1'b0, 16'h0000, 16'h0100, 16'h0200};
        rows[3] = {1'b1, 16'h0000, 16'h0300, 16'h0400};
        repeat (6) @(posedge clk);
        arst_n <= 1;
        for (i = 0; i < 4; i = i + 1)
            run(rows[i][48], rows[i][47:32], rows[i][31:16], rows[i][15:0], 1);
        run(0, 16'h0100, 16'h0010, 16'h0020, 1);
        run(1, 16'h0101, 16'h4000, 16'h5000, 1);
        slow = 1;
        run(0, 16'h0004, 16'h6000, 16'h7000, 0);
        // reset in mid-move: all back to idle, then a clean move
        slow = 0;
        es = src_in;
        ed = dst_in;
        @(posedge clk);
        start <= 1;
        count_in <= 16'h0010;
        @(posedge clk);
        start <= 0;
        repeat (10) @(posedge clk);
        arst_n <= 0;
        @(negedge clk);
        chk(busy_q, 0);
        chk(mem_req_q, 0);
        chk(count_q, 0);
        @(posedge clk);
        arst_n <= 1;
        run(1, 16'h0002, 16'h8000, 16'h9000, 1);
        final_report;
    end
    // watchdog well past the longest expected run
    initial begin
        #100000;
        mismatches = mismatches + 1;
        final_report;
    end
endmodule // tb
